/* File: verilog/step_timing_defines.vh */
// register offsets, field positions, reset values and state codes of step_timing_cfg
// assumes the includer wants plain `define names, no package
`ifndef STEP_TIMING_DEFINES_VH
`define STEP_TIMING_DEFINES_VH

`define ADDR_STEP_TIMING    8'h10
`define ADDR_START_OUT_ADD  8'h11
`define ADDR_STEP_INCR      8'h12
`define ADDR_START_DELAY    8'h13
`define ADDR_CLK_GATE_WAIT  8'h14
`define ADDR_STANDBY_WAIT   8'h15
`define ADDR_FREEWHEEL_WAIT 8'h16
`define ADDR_SCALE_VEL      8'h17
`define ADDR_SCALE_UP       8'h18
`define ADDR_SCALE_DOWN     8'h19
`define ADDR_CONTROL        8'h20
`define ADDR_DRIVE_SCALES   8'h21
`define ADDR_STATUS         8'h22
`define ADDR_POSITION       8'h23

`define RST_STEP_TIMING     32'h0000_0000
`define RST_WORD            32'h0000_0000
`define RST_STEP_INCR       32'h0100_0000
`define RST_FIELD24         24'h00_0000
`define RST_CONTROL         2'h0
`define RST_DRIVE_SCALES    24'h00_0000

// field positions in step timing word
`define STEP_EXT_LSB        0
`define DIR_SETUP_LSB       16
// control bits
`define CTRL_PWM_BIT        0
`define CTRL_CLOSED_BIT     1
// drive scale word fields
`define LOW_SCALE_LSB       0
`define HIGH_SCALE_LSB      8
`define HOLD_SCALE_LSB      16

// step output sequencer states
`define ST_IDLE             2'h0
`define ST_SETUP            2'h1
`define ST_HIGH             2'h2
`define ST_LOW              2'h3

`endif

/* File: verilog/step_timing_cfg.v */
// step/direction timing, start pulse, idle-phase delays and current scale stepping
// assumes synchronous inputs on i_clk_sys and a master that never waits for read data
`timescale 1ns/1ps
`include "step_timing_defines.vh"

module step_timing_cfg #(
  parameter SCALE_W = 8 // width of drive scale values
) (
  input  wire               i_clk_sys,          // 20 MHz system clock
  input  wire               i_resetn,           // async reset, active low
  input  wire [7:0]         i_addr,             // register address
  input  wire [31:0]        i_wr_data,          // write data
  input  wire               i_wr,               // write strobe
  input  wire               i_rd,               // read strobe
  output reg  [31:0]        o_rd_data,          // read data, cycle after i_rd
  input  wire               i_step_req,         // request one output step
  input  wire               i_step_dir,         // direction of requested step
  input  wire               i_step_input_pin,   // step input, rising edge active
  input  wire               i_start_trigger,    // start trigger pulse
  input  wire               i_clk_gate_req,     // clock gating request level
  input  wire               i_ramp_stop,        // ramp stopped level
  input  wire [23:0]        i_actual_velocity,  // actual velocity magnitude
  output reg                o_step_output_pin,  // step output
  output reg                o_direction_output_pin, // direction output
  output reg                o_step_busy,        // step sequencer busy
  output reg                o_start_out,        // start output
  output reg                o_start_release,    // internal start release pulse
  output reg                o_clk_gating,       // clock gating active
  output reg                o_standby,          // standby phase active
  output reg                o_freewheel,        // freewheeling active
  output reg                o_high_scale_sel,   // high speed drive scale selected
  output reg                o_pwm_full_scale,   // pwm velocity at full scale
  output reg  [SCALE_W-1:0] o_current_scale     // current scale value
);

  reg  [31:0]        step_timing;
  reg  [31:0]        start_pulse_extension;
  reg  [31:0]        step_input_increment;
  reg  [31:0]        start_release_delay;
  reg  [31:0]        clock_gate_wait;
  reg  [31:0]        standby_entry_wait;
  reg  [31:0]        freewheel_entry_wait;
  reg  [23:0]        scale_velocity;
  reg  [23:0]        scale_up_interval;
  reg  [23:0]        scale_down_interval;
  reg  [1:0]         control;
  reg  [23:0]        drive_scales;
  reg  [31:0]        position;
  reg  [1:0]         step_state;
  reg  [15:0]        step_cnt;
  reg  [31:0]        start_cnt;
  reg                start_wait;
  reg  [31:0]        start_len;
  reg  [31:0]        gate_cnt;
  reg  [31:0]        standby_cnt;
  reg  [31:0]        freewheel_cnt;
  reg  [23:0]        scale_cnt;
  reg                step_in_prev;
  reg  [31:0]        next_rd_data;

  wire [15:0]        step_ext    = step_timing[`STEP_EXT_LSB +: 16];
  wire [15:0]        dir_setup   = step_timing[`DIR_SETUP_LSB +: 16];
  wire               pwm_mode    = control[`CTRL_PWM_BIT];
  wire               closed_loop = control[`CTRL_CLOSED_BIT];
  wire [SCALE_W-1:0] low_scale   = drive_scales[`LOW_SCALE_LSB +: SCALE_W];
  wire [SCALE_W-1:0] high_scale  = drive_scales[`HIGH_SCALE_LSB +: SCALE_W];
  wire [SCALE_W-1:0] hold_scale  = drive_scales[`HOLD_SCALE_LSB +: SCALE_W];
  wire               vel_above   = i_actual_velocity > scale_velocity;
  wire               use_high    = !pwm_mode && vel_above;
  wire [SCALE_W-1:0] run_scale   = use_high ? high_scale : low_scale;
  wire [SCALE_W-1:0] scale_target = i_ramp_stop ? hold_scale : run_scale;
  wire               scale_up    = o_current_scale < scale_target;
  wire               scale_dn    = o_current_scale > scale_target;
  // one storage per offset; open and closed loop read the same field
  wire [23:0]        scale_ivl   = scale_up ? scale_up_interval : scale_down_interval;

  // register writes
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      step_timing           <= `RST_STEP_TIMING;
      start_pulse_extension <= `RST_WORD;
      step_input_increment  <= `RST_STEP_INCR;
      start_release_delay   <= `RST_WORD;
      clock_gate_wait       <= `RST_WORD;
      standby_entry_wait    <= `RST_WORD;
      freewheel_entry_wait  <= `RST_WORD;
      scale_velocity        <= `RST_FIELD24;
      scale_up_interval     <= `RST_FIELD24;
      scale_down_interval   <= `RST_FIELD24;
      control               <= `RST_CONTROL;
      drive_scales          <= `RST_DRIVE_SCALES;
    end
    else if (i_wr)
    begin
      case (i_addr)
        `ADDR_STEP_TIMING:    step_timing           <= i_wr_data;
        `ADDR_START_OUT_ADD:  start_pulse_extension <= i_wr_data;
        `ADDR_STEP_INCR:      step_input_increment  <= i_wr_data;
        `ADDR_START_DELAY:    start_release_delay   <= i_wr_data;
        `ADDR_CLK_GATE_WAIT:  clock_gate_wait       <= i_wr_data;
        `ADDR_STANDBY_WAIT:   standby_entry_wait    <= i_wr_data;
        `ADDR_FREEWHEEL_WAIT: freewheel_entry_wait  <= i_wr_data;
        `ADDR_SCALE_VEL:      scale_velocity        <= i_wr_data[23:0];
        `ADDR_SCALE_UP:       scale_up_interval     <= i_wr_data[23:0];
        `ADDR_SCALE_DOWN:     scale_down_interval   <= i_wr_data[23:0];
        `ADDR_CONTROL:        control               <= i_wr_data[1:0];
        `ADDR_DRIVE_SCALES:   drive_scales          <= i_wr_data[23:0];
        default:              control               <= control;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always @*
  begin
    next_rd_data = 32'h0000_0000;
    case (i_addr)
      `ADDR_STEP_TIMING:    next_rd_data = step_timing;
      `ADDR_START_OUT_ADD:  next_rd_data = start_pulse_extension;
      `ADDR_STEP_INCR:      next_rd_data = step_input_increment;
      `ADDR_START_DELAY:    next_rd_data = start_release_delay;
      `ADDR_CLK_GATE_WAIT:  next_rd_data = clock_gate_wait;
      `ADDR_STANDBY_WAIT:   next_rd_data = standby_entry_wait;
      `ADDR_FREEWHEEL_WAIT: next_rd_data = freewheel_entry_wait;
      `ADDR_SCALE_VEL:      next_rd_data = {8'h00, scale_velocity};
      `ADDR_SCALE_UP:       next_rd_data = {8'h00, scale_up_interval};
      `ADDR_SCALE_DOWN:     next_rd_data = {8'h00, scale_down_interval};
      `ADDR_CONTROL:        next_rd_data = {30'h0000_0000, control};
      `ADDR_DRIVE_SCALES:   next_rd_data = {8'h00, drive_scales};
      `ADDR_STATUS:
        next_rd_data = {16'h0000, o_current_scale, o_pwm_full_scale, o_high_scale_sel,
                        o_freewheel, o_standby, o_clk_gating, o_start_out,
                        o_step_busy, o_direction_output_pin};
      `ADDR_POSITION:       next_rd_data = position;
      default:              next_rd_data = 32'h0000_0000;
    endcase
  end

  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_rd_data <= 32'h0000_0000;
    else if (i_rd)
      o_rd_data <= next_rd_data;
    else
      o_rd_data <= 32'h0000_0000;
  end

  // step output sequencer; requests while busy are dropped
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      step_state             <= `ST_IDLE;
      step_cnt               <= 16'h0000;
      o_step_output_pin      <= 1'b0;
      o_direction_output_pin <= 1'b0;
      o_step_busy            <= 1'b0;
    end
    else
    begin
      case (step_state)
        `ST_IDLE:
          if (i_step_req)
          begin
            o_step_busy <= 1'b1;
            if (i_step_dir != o_direction_output_pin)
            begin
              o_direction_output_pin <= i_step_dir;
              step_cnt               <= dir_setup;
              step_state             <= `ST_SETUP;
            end
            else
            begin
              o_step_output_pin <= 1'b1;
              step_cnt          <= step_ext;
              step_state        <= `ST_HIGH;
            end
          end
        `ST_SETUP:
          if (step_cnt == 16'h0000)
          begin
            o_step_output_pin <= 1'b1;
            step_cnt          <= step_ext;
            step_state        <= `ST_HIGH;
          end
          else
            step_cnt <= step_cnt - 16'h0001;
        `ST_HIGH:
          if (step_cnt == 16'h0000)
          begin
            o_step_output_pin <= 1'b0;
            step_state        <= `ST_LOW;
          end
          else
            step_cnt <= step_cnt - 16'h0001;
        `ST_LOW:
        begin
          // one low cycle guarantees a visible inactive level between steps
          o_step_busy <= 1'b0;
          step_state  <= `ST_IDLE;
        end
        default:
          step_state <= `ST_IDLE;
      endcase
    end
  end

  // input steps into the internal position
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      step_in_prev <= 1'b0;
      position     <= 32'h0000_0000;
    end
    else
    begin
      step_in_prev <= i_step_input_pin;
      if (i_step_input_pin && !step_in_prev)
        position <= position + step_input_increment;
    end
  end

  // start trigger: delay, then release pulse and stretched start output in the same cycle
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      start_wait      <= 1'b0;
      start_cnt       <= 32'h0000_0000;
      start_len       <= 32'h0000_0000;
      o_start_release <= 1'b0;
      o_start_out     <= 1'b0;
    end
    else
    begin
      o_start_release <= 1'b0;
      if (i_start_trigger && !start_wait)
      begin
        start_wait <= 1'b1;
        start_cnt  <= start_release_delay;
      end
      else if (start_wait)
      begin
        if (start_cnt == 32'h0000_0000)
        begin
          start_wait      <= 1'b0;
          o_start_release <= 1'b1;
          o_start_out     <= 1'b1;
          start_len       <= start_pulse_extension;
        end
        else
          start_cnt <= start_cnt - 32'h0000_0001;
      end
      if (o_start_out && !(start_wait && start_cnt == 32'h0000_0000))
      begin
        if (start_len == 32'h0000_0000)
          o_start_out <= 1'b0;
        else
          start_len <= start_len - 32'h0000_0001;
      end
    end
  end

  // clock gating, standby and freewheel waits
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      gate_cnt      <= 32'h0000_0000;
      standby_cnt   <= 32'h0000_0000;
      freewheel_cnt <= 32'h0000_0000;
      o_clk_gating  <= 1'b0;
      o_standby     <= 1'b0;
      o_freewheel   <= 1'b0;
    end
    else
    begin
      if (!i_clk_gate_req)
      begin
        gate_cnt     <= 32'h0000_0000;
        o_clk_gating <= 1'b0;
      end
      else if (gate_cnt >= clock_gate_wait)
        o_clk_gating <= 1'b1;
      else
        gate_cnt <= gate_cnt + 32'h0000_0001;

      if (!i_ramp_stop)
      begin
        standby_cnt   <= 32'h0000_0000;
        freewheel_cnt <= 32'h0000_0000;
        o_standby     <= 1'b0;
        o_freewheel   <= 1'b0;
      end
      else if (!o_standby)
      begin
        if (standby_cnt >= standby_entry_wait)
          o_standby <= 1'b1;
        else
          standby_cnt <= standby_cnt + 32'h0000_0001;
      end
      else if (freewheel_cnt >= freewheel_entry_wait)
        o_freewheel <= 1'b1;
      else
        freewheel_cnt <= freewheel_cnt + 32'h0000_0001;
    end
  end

  // drive scale choice and stepped current scale
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_high_scale_sel <= 1'b0;
      o_pwm_full_scale <= 1'b0;
      o_current_scale  <= {SCALE_W{1'b0}};
      scale_cnt        <= 24'h00_0000;
    end
    else
    begin
      o_high_scale_sel <= use_high;
      o_pwm_full_scale <= pwm_mode && !(i_actual_velocity < scale_velocity);
      if (!scale_up && !scale_dn)
        scale_cnt <= 24'h00_0000;
      else if (scale_cnt >= scale_ivl)
      begin
        scale_cnt <= 24'h00_0000;
        if (scale_up)
          o_current_scale <= o_current_scale + {{(SCALE_W-1){1'b0}}, 1'b1};
        else if (closed_loop)
          o_current_scale <= o_current_scale - {{(SCALE_W-1){1'b0}}, 1'b1};
        else
          o_current_scale <= o_current_scale - {{(SCALE_W-1){1'b0}}, 1'b1};
      end
      else
        scale_cnt <= scale_cnt + 24'h00_0001;
    end
  end

endmodule // step_timing_cfg

/* File: testbench/step_timing_monitor.sv */
// checker: timing relations on the step_timing_cfg ports
// assumes one bus master and the single i_clk_sys domain
`timescale 1ns/1ps
module step_timing_monitor (
  input wire        i_clk_sys,              // clock
  input wire        i_resetn,               // reset, active low
  input wire [7:0]  i_addr,                 // address
  input wire [31:0] i_wr_data,              // write data
  input wire        i_wr,                   // write strobe
  input wire [23:0] i_actual_velocity,      // velocity
  input wire        o_step_output_pin,      // step out
  input wire        o_direction_output_pin, // direction out
  input wire        o_start_out,            // start out
  input wire        o_start_release,        // start release
  input wire        o_standby,              // standby
  input wire        o_freewheel,            // freewheel
  input wire        o_high_scale_sel,       // high scale
  input wire        o_pwm_full_scale        // pwm full
);
  // shadows of the timing fields, so lengths can be judged at the pins
  reg  [31:0] st_w, so_w, srun, prun, gap;
  reg  [23:0] lim;
  reg  [1:0]  ctl;
  reg         dq;
  wire        hs = !ctl[0] && (i_actual_velocity > lim);
  wire        pf = ctl[0] && (i_actual_velocity >= lim);
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_w <= 32'h0000_0000;
      so_w <= 32'h0000_0000;
      lim  <= 24'h00_0000;
      ctl  <= 2'h0;
      srun <= 32'h0000_0000;
      prun <= 32'h0000_0000;
      gap  <= 32'h0000_0000;
      dq   <= 1'b0;
    end
    else
    begin
      if (i_wr && i_addr == 8'h10) st_w <= i_wr_data;
      if (i_wr && i_addr == 8'h11) so_w <= i_wr_data;
      if (i_wr && i_addr == 8'h17) lim <= i_wr_data[23:0];
      if (i_wr && i_addr == 8'h20) ctl <= i_wr_data[1:0];
      srun <= o_step_output_pin ? srun + 32'h1 : 32'h0;
      prun <= o_start_out ? prun + 32'h1 : 32'h0;
      gap  <= (o_direction_output_pin != dq) ? 32'h0 : gap + 32'h1;
      dq   <= o_direction_output_pin;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  property p_step_len;
    $fell(o_step_output_pin) |-> srun == {16'h0000, st_w[15:0]} + 32'h1;
  endproperty
  a_step_len: assert property (p_step_len) else $error("step pulse length");
  property p_dir_setup;
    $rose(o_step_output_pin) |-> gap >= {16'h0000, st_w[31:16]};
  endproperty
  a_dir_setup: assert property (p_dir_setup) else $error("direction setup");
  property p_start_len;
    $fell(o_start_out) |-> prun == so_w + 32'h1;
  endproperty
  a_start_len: assert property (p_start_len) else $error("start length");
  property p_start_rise;
    $rose(o_start_out) |-> o_start_release;
  endproperty
  a_start_rise: assert property (p_start_rise) else $error("start rise");
  property p_release_once;
    o_start_release |=> !o_start_release;
  endproperty
  a_release_once: assert property (p_release_once) else $error("release width");
  property p_free_stdby;
    o_freewheel |-> o_standby;
  endproperty
  a_free_stdby: assert property (p_free_stdby) else $error("freewheel order");
  property p_high_sel;
    1 |=> o_high_scale_sel == $past(hs);
  endproperty
  a_high_sel: assert property (p_high_sel) else $error("high scale select");
  property p_pwm_full;
    1 |=> o_pwm_full_scale == $past(pf);
  endproperty
  a_pwm_full: assert property (p_pwm_full) else $error("pwm full scale");
  property p_mode_excl;
    !(o_high_scale_sel && o_pwm_full_scale);
  endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("field meaning");
  c_step: cover property ($rose(o_step_output_pin));
  c_start: cover property (o_start_release);
  c_free: cover property ($rose(o_freewheel));
endmodule // step_timing_monitor

bind step_timing_cfg step_timing_monitor u_mon (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr(i_wr), .i_actual_velocity(i_actual_velocity),
  .o_step_output_pin(o_step_output_pin), .o_direction_output_pin(o_direction_output_pin),
  .o_start_out(o_start_out), .o_start_release(o_start_release), .o_standby(o_standby),
  .o_freewheel(o_freewheel), .o_high_scale_sel(o_high_scale_sel),
  .o_pwm_full_scale(o_pwm_full_scale));

/* File: testbench/step_driver_model.sv */
// behavioural stepper driver on the step and direction lines
// assumes an active-high step sampled on the system clock
`timescale 1ns/1ps
module step_driver_model (
  input  wire        i_clk_sys,  // clock
  input  wire        i_resetn,   // reset, active low
  input  wire        i_step,     // step line
  input  wire        i_dir,      // direction line
  output reg  [15:0] o_fwd,      // forward steps
  output reg  [15:0] o_rev,      // reverse steps
  output reg         o_setup_err // direction moved in a step
);
  reg step_q, dir_q;
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      {step_q, dir_q, o_setup_err} <= 3'h0;
      o_fwd <= 16'h0000;
      o_rev <= 16'h0000;
    end
    else
    begin
      step_q <= i_step;
      dir_q  <= i_dir;
      if (i_step && !step_q && i_dir) o_fwd <= o_fwd + 16'h1;
      if (i_step && !step_q && !i_dir) o_rev <= o_rev + 16'h1;
      if (i_step && i_dir != dir_q) o_setup_err <= 1'b1;
    end
  end
endmodule // step_driver_model

/* File: testbench/tb.sv */
// self-checking bench for step_timing_cfg with a driver model on step/dir
// assumes the single-cycle register port and registered outputs
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module tb;
  reg         i_clk_sys, i_resetn, i_wr, i_rd, i_step_req, i_step_dir;
  reg         i_step_input_pin, i_start_trigger, i_clk_gate_req, i_ramp_stop;
  reg  [7:0]  i_addr;
  reg  [31:0] i_wr_data;
  reg  [23:0] i_actual_velocity;
  wire [31:0] o_rd_data;
  wire [7:0]  o_current_scale;
  wire        o_step_output_pin, o_direction_output_pin, o_step_busy, o_start_out;
  wire        o_start_release, o_clk_gating, o_standby, o_freewheel;
  wire        o_high_scale_sel, o_pwm_full_scale, setup_err;
  wire [15:0] fwd, rev;
  wire [5:0]  mon = {o_start_out, o_freewheel, o_standby, o_clk_gating,
                     o_start_release, o_step_output_pin};
  integer     bad_count = 0, check_count = 0, n, m;
  step_timing_cfg dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_step_req(i_step_req), .i_step_dir(i_step_dir), .i_step_input_pin(i_step_input_pin),
    .i_start_trigger(i_start_trigger), .i_clk_gate_req(i_clk_gate_req),
    .i_ramp_stop(i_ramp_stop), .i_actual_velocity(i_actual_velocity),
    .o_step_output_pin(o_step_output_pin), .o_direction_output_pin(o_direction_output_pin),
    .o_step_busy(o_step_busy), .o_start_out(o_start_out), .o_start_release(o_start_release),
    .o_clk_gating(o_clk_gating), .o_standby(o_standby), .o_freewheel(o_freewheel),
    .o_high_scale_sel(o_high_scale_sel), .o_pwm_full_scale(o_pwm_full_scale),
    .o_current_scale(o_current_scale));
  step_driver_model u_drv (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_step(o_step_output_pin), .i_dir(o_direction_output_pin), .o_fwd(fwd), .o_rev(rev),
    .o_setup_err(setup_err));
  task end_of_test;
  begin
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge i_clk_sys);
    {i_wr, i_addr, i_wr_data} <= {1'b1, a, d};
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
  begin
    @(posedge i_clk_sys);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rd_data, e)
  end
  endtask
  // edges until a watched output reaches a level; bounded against hangs
  task cnt(input integer b, input lvl, output integer k);
  begin
    k = 0;
    while (mon[b] !== lvl && k < 300)
    begin
      @(posedge i_clk_sys);
      #1;
      k = k + 1;
    end
    if (k >= 300) bad_count++;
    if (k >= 300) end_of_test;
  end
  endtask
  task sgap(output integer k);
    reg [7:0] s;
  begin
    s = o_current_scale;
    k = 0;
    while (o_current_scale === s && k < 300)
    begin
      @(posedge i_clk_sys);
      #1;
      k = k + 1;
    end
    if (k >= 300) bad_count++;
    if (k >= 300) end_of_test;
  end
  endtask
  task pulse(input integer lvl_mask, input integer sel);
  begin
    @(posedge i_clk_sys);
    if (sel == 0) i_step_input_pin <= 1'b1;
    if (sel == 1) {i_step_req, i_step_dir} <= {1'b1, lvl_mask[0]};
    if (sel == 2) i_start_trigger <= 1'b1;
    @(posedge i_clk_sys);
    {i_step_input_pin, i_step_req, i_start_trigger} <= 3'h0;
    #1;
  end
  endtask
  initial
  begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    {i_resetn, i_wr, i_rd, i_step_req, i_step_dir, i_step_input_pin} = 6'h0;
    {i_start_trigger, i_clk_gate_req, i_ramp_stop, i_addr, i_wr_data} = 43'h0;
    i_actual_velocity = 24'h00_0000;
    repeat (10) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    for (m = 16; m < 26; m++) rdc(m[7:0], m == 18 ? 32'h0100_0000 : 32'h0000_0000);
    wr(8'h30, 32'hFFFF_FFFF);
    rdc(8'h30, 32'h0000_0000);
    wr(8'h10, 32'h0003_0002);
    rdc(8'h10, 32'h0003_0002);
    pulse(0, 0);
    wr(8'h12, 32'hFF00_0000);
    pulse(0, 0);
    pulse(0, 0);
    wr(8'h12, 32'h0080_0000);
    pulse(0, 0);
    wr(8'h23, 32'h1234_5678);
    repeat (4) @(posedge i_clk_sys);
    rdc(8'h23, 32'hFF80_0000);
    for (m = 0; m < 3; m++)
    begin
      pulse(m < 2, 1);
      cnt(0, 1'b1, n);
      `CHK(n, (m == 1) ? 0 : 4)
      cnt(0, 1'b0, n);
      `CHK(n, 3)
      `CHK(o_step_busy, 1'b1)
      repeat (2) @(posedge i_clk_sys);
    end
    `CHK(({fwd, rev, setup_err}), ({16'h0002, 16'h0001, 1'b0}))
    for (m = 0; m < 2; m++)
    begin
      wr(8'h13, 4 * m);
      wr(8'h11, 2 * m);
      pulse(0, 2);
      cnt(1, 1'b1, n);
      `CHK(n, 1 + 4 * m)
      cnt(5, 1'b0, n);
      `CHK(n, 1 + 2 * m)
    end
    wr(8'h14, 32'h0000_0003);
    wr(8'h15, 32'h0000_0002);
    wr(8'h16, 32'h0000_0003);
    @(posedge i_clk_sys) {i_clk_gate_req, i_ramp_stop} <= 2'h3;
    @(posedge i_clk_sys) #1;
    cnt(2, 1'b1, n);
    `CHK(n, 3)
    cnt(4, 1'b1, n);
    `CHK(n, 3)
    @(posedge i_clk_sys) {i_clk_gate_req, i_ramp_stop} <= 2'h0;
    cnt(3, 1'b0, n);
    @(posedge i_clk_sys) i_ramp_stop <= 1'b1;
    @(posedge i_clk_sys) #1;
    cnt(3, 1'b1, n);
    `CHK(n, 2)
    wr(8'h17, 32'h0000_0100);
    @(posedge i_clk_sys) i_actual_velocity <= 24'h00_0200;
    for (m = 0; m < 2; m++)
    begin
      wr(8'h20, 2 * m);
      wr(8'h18, 1 + m);
      wr(8'h19, m);
      wr(8'h21, 32'h0002_0904);
      @(posedge i_clk_sys) i_ramp_stop <= 1'b0;
      #1;
      sgap(n);
      sgap(n);
      `CHK(n, 2 + m)
      // climb well above hold so the fall has steps left to time
      repeat (8) @(posedge i_clk_sys);
      @(posedge i_clk_sys) i_ramp_stop <= 1'b1;
      #1;
      sgap(n);
      sgap(n);
      `CHK(n, 1 + m)
    end
    repeat (20) @(posedge i_clk_sys);
    #1;
    `CHK(o_current_scale, 8'h02)
    `CHK(({o_high_scale_sel, o_pwm_full_scale}), 2'h2)
    wr(8'h20, 32'h0000_0001);
    repeat (2) @(posedge i_clk_sys);
    #1;
    `CHK(({o_high_scale_sel, o_pwm_full_scale}), 2'h1)
    end_of_test;
  end
endmodule // tb
